// file: hdl/gpio_pkg.sv
// Package with register map, field widths, reset values and carriers of the port
`default_nettype none
package gpio_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_DATA_BASE = 12'h000; // Masked data window base
    localparam logic [11:0] OFS_DATA_LAST = 12'h3fc; // Last word of data window
    localparam logic [11:0] OFS_DIR = 12'h400;
    localparam logic [11:0] OFS_IS = 12'h404;
    localparam logic [11:0] OFS_IBE = 12'h408;
    localparam logic [11:0] OFS_IEV = 12'h40c;
    localparam logic [11:0] OFS_IM = 12'h410;
    localparam logic [11:0] OFS_RIS = 12'h414;
    localparam logic [11:0] OFS_MIS = 12'h418;
    localparam logic [11:0] OFS_ICR = 12'h41c;
    localparam logic [11:0] OFS_AFSEL = 12'h420;
    localparam logic [11:0] OFS_DRLO = 12'h500;
    localparam logic [11:0] OFS_DRMID = 12'h504;
    localparam logic [11:0] OFS_DRHI = 12'h508;
    localparam logic [11:0] OFS_ODR = 12'h50c;
    localparam logic [11:0] OFS_PUR = 12'h510;
    localparam logic [11:0] OFS_PDR = 12'h514;
    localparam logic [11:0] OFS_SLR = 12'h518;
    localparam logic [11:0] OFS_DEN = 12'h51c;
    localparam logic [11:0] OFS_LOCK = 12'h520;
    localparam logic [11:0] OFS_CR = 12'h524;
    localparam logic [11:0] OFS_BLOCK_ID = 12'hfe0;
    localparam logic [11:0] OFS_CELL_ID = 12'hff0;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int MASK_LSB = 2; // Address bits 9..2 form the data mask
    localparam int MASK_MSB = 9;
    localparam logic [7:0] RST_DRLO = 8'hff;
    localparam logic [7:0] RST_CR_FREE = 8'hff; // Commit value for unprotected pins
    localparam logic [31:0] UNLOCK_KEY = 32'h0000_5a5a; // Unlock key, arbitrary value
    localparam logic [31:0] LOCKED_READ = 32'h0000_0001; // Lock reads 1 while locked
    localparam logic [7:0] BLOCK_ID_VAL = 8'h5a; // Arbitrary identification value
    localparam logic [7:0] CELL_ID_VAL = 8'ha5; // Arbitrary identification value
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] drive_low_select;
        logic [7:0] drive_mid_select;
        logic [7:0] drive_high_select;
        logic [7:0] open_drain_select;
        logic [7:0] pull_up_select;
        logic [7:0] pull_down_select;
        logic [7:0] slew_control_select;
        logic [7:0] digital_enable;
    } pad_cfg_t;
    typedef struct packed {
        logic [7:0] sense; // 0 edge, 1 level
        logic [7:0] both; // 1 both edges
        logic [7:0] polarity; // 1 high or rising
    } trig_cfg_t;
endpackage
`default_nettype wire

// file: hdl/gpio_sync.sv
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module gpio_sync #(
    parameter int WIDTH = 8
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r; // First stage, read only by the second

    // ------------------------------------------------------------
    // Two flops; reset clears both
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// file: hdl/gpio_irq_detect.sv
// Per-pin edge and level detector producing sticky raw status
`timescale 1ns/1ps
`default_nettype none
module gpio_irq_detect #(
    parameter int WIDTH = 8
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [WIDTH-1:0] pin_sync,
    input wire gpio_pkg::trig_cfg_t cfg,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] raw
);
    logic [WIDTH-1:0] prev_r; // Last sampled pin level
    logic [WIDTH-1:0] hit; // Condition met this cycle

    // ------------------------------------------------------------
    // Trigger condition per pin
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (cfg.sense[i]) begin
                // Level: active level itself
                hit[i] = (pin_sync[i] == cfg.polarity[i]);
            end else if (cfg.both[i]) begin
                // Either edge
                hit[i] = pin_sync[i] ^ prev_r[i];
            end else begin
                // Single edge of chosen polarity
                hit[i] = (pin_sync[i] ^ prev_r[i]) & (pin_sync[i] == cfg.polarity[i]);
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            prev_r <= '0;
        end else begin
            prev_r <= pin_sync;
        end
    end

    // ------------------------------------------------------------
    // Sticky status; a new hit wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            raw <= '0;
        end else begin
            raw <= (raw & ~clear) | hit;
        end
    end
endmodule
`default_nettype wire

// file: hdl/gpio_port.sv
// General-purpose I/O port with masked data access, pin interrupts and pad control
//
// Operation
// - Address bits 9..2 mask data accesses
// - Data register spans 256 word locations
// - Writes change only mask-selected bits
// - Reads return zero for unmasked bits
// - All pin interrupts merge into one output
// - Edge interrupts stay pending until cleared
// - Sense, both-edges, event bits select trigger
// - Mask bit one forwards pin interrupt
// - Masked status shows only enabled pending
// - Raw status sets regardless of mask
// - Unmasked trigger pin also pulses converter
// - Writing one to clear register clears
// - Alternate-function bit hands pin to peripheral
// - Protected pins need unlock and commit for alternate-function changes; their pad settings stay freely writable
// - Pad settings held and driven to pad
// - Reset clears pad enables on normal pins
// - Read-only identification registers with fixed values
// - Direction zero input, one output
// - Protected pins reset to debug function
`timescale 1ns/1ps
`default_nettype none
module gpio_port #(
    parameter int WIDTH = 8,
    parameter logic [7:0] PROTECTED = 8'h00, // Debug pins guarded by commit
    parameter int TRIG_PIN = 4 // Pin that also triggers the converter
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic [7:0] PIN_IN,
    output logic [7:0] PIN_OUT,
    output logic [7:0] PIN_OE,
    input wire logic [7:0] ALT_OUT,
    input wire logic [7:0] ALT_OE,
    output logic [7:0] ALT_IN,
    output var gpio_pkg::pad_cfg_t PAD_CFG,
    output logic IRQ,
    output logic CONV_TRIGGER
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (WIDTH != 8) begin : g_width_chk
        $error("gpio_port supports only eight pins");
    end
    if (TRIG_PIN < 0 || TRIG_PIN >= WIDTH) begin : g_trig_chk
        $error("TRIG_PIN out of range");
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] data_r; // Output data latch
    logic [7:0] pin_direction_r; // 1 output
    gpio_pkg::trig_cfg_t trig_r; // Trigger selection
    logic [7:0] irq_mask_r; // 1 forwards
    logic [7:0] alt_function_select_r;
    gpio_pkg::pad_cfg_t pad_r;
    logic unlocked_r; // Lock opened by key
    logic [7:0] config_commit_r;
    logic [7:0] pin_sync; // Synchronised pins
    logic [7:0] irq_raw_status;
    logic [7:0] irq_masked_status;
    logic [7:0] clear_pulse; // Clear strobe to detector
    logic [7:0] pin_value; // Value seen by data reads
    logic [7:0] addr_mask; // Mask from address
    logic is_data; // Address inside data window
    logic trig_pend_r; // Previous masked trigger state
    logic [31:0] rdata_nxt;

    // Mask extraction, used by read and write paths
    function automatic logic [7:0] mask_of(input logic [11:0] a);
        return a[gpio_pkg::MASK_MSB:gpio_pkg::MASK_LSB];
    endfunction

    // Write hits a given offset
    function automatic logic wr_hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    assign addr_mask = mask_of(ADDR);
    assign is_data = (ADDR <= gpio_pkg::OFS_DATA_LAST);

    // ------------------------------------------------------------
    // Input synchroniser and detector
    // ------------------------------------------------------------
    gpio_sync #(.WIDTH(8)) u_sync (
        .CORE_CLK(CORE_CLK),
        .RESET(RESET),
        .d(PIN_IN),
        .q(pin_sync)
    );

    assign clear_pulse = (WR && wr_hit(ADDR, gpio_pkg::OFS_ICR)) ? WDATA[7:0] : 8'h00;

    gpio_irq_detect #(.WIDTH(8)) u_det (
        .CORE_CLK(CORE_CLK),
        .RESET(RESET),
        .pin_sync(pin_sync),
        .cfg(trig_r),
        .clear(clear_pulse),
        .raw(irq_raw_status)
    );

    assign irq_masked_status = irq_raw_status & irq_mask_r;
    assign IRQ = |irq_masked_status;

    // ------------------------------------------------------------
    // Converter trigger: one pulse when the masked status of the trigger pin sets
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            trig_pend_r <= 1'b0;
            CONV_TRIGGER <= 1'b0;
        end else begin
            trig_pend_r <= irq_masked_status[TRIG_PIN];
            CONV_TRIGGER <= irq_masked_status[TRIG_PIN] & ~trig_pend_r;
        end
    end

    // ------------------------------------------------------------
    // Data latch: masked writes only
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            data_r <= 8'h00;
        end else if (WR && is_data) begin
            data_r <= (data_r & ~addr_mask) | (WDATA[7:0] & addr_mask);
        end
    end

    // ------------------------------------------------------------
    // Direction and interrupt configuration
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            pin_direction_r <= 8'h00;
            trig_r <= '0;
            irq_mask_r <= 8'h00;
        end else if (WR) begin
            if (wr_hit(ADDR, gpio_pkg::OFS_DIR)) begin
                pin_direction_r <= WDATA[7:0];
            end else if (wr_hit(ADDR, gpio_pkg::OFS_IS)) begin
                trig_r.sense <= WDATA[7:0];
            end else if (wr_hit(ADDR, gpio_pkg::OFS_IBE)) begin
                trig_r.both <= WDATA[7:0];
            end else if (wr_hit(ADDR, gpio_pkg::OFS_IEV)) begin
                trig_r.polarity <= WDATA[7:0];
            end else if (wr_hit(ADDR, gpio_pkg::OFS_IM)) begin
                irq_mask_r <= WDATA[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Lock and commit
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            unlocked_r <= 1'b0;
        end else if (WR && wr_hit(ADDR, gpio_pkg::OFS_LOCK)) begin
            // Any other value relocks
            unlocked_r <= (WDATA == gpio_pkg::UNLOCK_KEY);
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            config_commit_r <= gpio_pkg::RST_CR_FREE & ~PROTECTED;
        end else if (WR && unlocked_r && wr_hit(ADDR, gpio_pkg::OFS_CR)) begin
            // Only protected bits are writable; the rest stay committable
            config_commit_r <= (WDATA[7:0] & PROTECTED) | ~PROTECTED;
        end
    end

    // ------------------------------------------------------------
    // Alternate function select, guarded for protected pins
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            alt_function_select_r <= PROTECTED;
        end else if (WR && wr_hit(ADDR, gpio_pkg::OFS_AFSEL)) begin
            for (int i = 0; i < 8; i++) begin
                // Protected bit changes only when unlocked and committed
                if (!PROTECTED[i] || (unlocked_r && config_commit_r[i])) begin
                    alt_function_select_r[i] <= WDATA[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pad configuration storage
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            pad_r <= '0;
            pad_r.drive_low_select <= gpio_pkg::RST_DRLO;
            pad_r.pull_up_select <= PROTECTED;
            pad_r.digital_enable <= PROTECTED;
        end else if (WR) begin
            if (wr_hit(ADDR, gpio_pkg::OFS_DRLO)) begin
                pad_r.drive_low_select <= WDATA[7:0];
            end else if (wr_hit(ADDR, gpio_pkg::OFS_DRMID)) begin
                pad_r.drive_mid_select <= WDATA[7:0];
            end else if (wr_hit(ADDR, gpio_pkg::OFS_DRHI)) begin
                pad_r.drive_high_select <= WDATA[7:0];
            end else if (wr_hit(ADDR, gpio_pkg::OFS_ODR)) begin
                pad_r.open_drain_select <= WDATA[7:0];
            end else if (wr_hit(ADDR, gpio_pkg::OFS_PUR)) begin
                pad_r.pull_up_select <= WDATA[7:0];
            end else if (wr_hit(ADDR, gpio_pkg::OFS_PDR)) begin
                pad_r.pull_down_select <= WDATA[7:0];
            end else if (wr_hit(ADDR, gpio_pkg::OFS_SLR)) begin
                pad_r.slew_control_select <= WDATA[7:0];
            end else if (wr_hit(ADDR, gpio_pkg::OFS_DEN)) begin
                pad_r.digital_enable <= WDATA[7:0];
            end
        end
    end

    assign PAD_CFG = pad_r;

    // ------------------------------------------------------------
    // Pin muxing: peripheral or data register
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (alt_function_select_r[i]) begin
                PIN_OUT[i] = ALT_OUT[i];
                PIN_OE[i] = ALT_OE[i] & pad_r.digital_enable[i];
            end else begin
                PIN_OUT[i] = data_r[i];
                PIN_OE[i] = pin_direction_r[i] & pad_r.digital_enable[i];
            end
        end
    end
    // Peripherals see the input only on their own pins
    assign ALT_IN = pin_sync & alt_function_select_r & pad_r.digital_enable;
    // Outputs read back latched value, inputs read the pin
    assign pin_value = (pin_direction_r & data_r) | (~pin_direction_r & pin_sync);

    // ------------------------------------------------------------
    // Read mux; unmapped offsets read zero
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (is_data) begin
            rdata_nxt[7:0] = pin_value & addr_mask;
        end else if (ADDR == gpio_pkg::OFS_DIR) begin
            rdata_nxt[7:0] = pin_direction_r;
        end else if (ADDR == gpio_pkg::OFS_IS) begin
            rdata_nxt[7:0] = trig_r.sense;
        end else if (ADDR == gpio_pkg::OFS_IBE) begin
            rdata_nxt[7:0] = trig_r.both;
        end else if (ADDR == gpio_pkg::OFS_IEV) begin
            rdata_nxt[7:0] = trig_r.polarity;
        end else if (ADDR == gpio_pkg::OFS_IM) begin
            rdata_nxt[7:0] = irq_mask_r;
        end else if (ADDR == gpio_pkg::OFS_RIS) begin
            rdata_nxt[7:0] = irq_raw_status;
        end else if (ADDR == gpio_pkg::OFS_MIS) begin
            rdata_nxt[7:0] = irq_masked_status;
        end else if (ADDR == gpio_pkg::OFS_AFSEL) begin
            rdata_nxt[7:0] = alt_function_select_r;
        end else if (ADDR == gpio_pkg::OFS_DRLO) begin
            rdata_nxt[7:0] = pad_r.drive_low_select;
        end else if (ADDR == gpio_pkg::OFS_DRMID) begin
            rdata_nxt[7:0] = pad_r.drive_mid_select;
        end else if (ADDR == gpio_pkg::OFS_DRHI) begin
            rdata_nxt[7:0] = pad_r.drive_high_select;
        end else if (ADDR == gpio_pkg::OFS_ODR) begin
            rdata_nxt[7:0] = pad_r.open_drain_select;
        end else if (ADDR == gpio_pkg::OFS_PUR) begin
            rdata_nxt[7:0] = pad_r.pull_up_select;
        end else if (ADDR == gpio_pkg::OFS_PDR) begin
            rdata_nxt[7:0] = pad_r.pull_down_select;
        end else if (ADDR == gpio_pkg::OFS_SLR) begin
            rdata_nxt[7:0] = pad_r.slew_control_select;
        end else if (ADDR == gpio_pkg::OFS_DEN) begin
            rdata_nxt[7:0] = pad_r.digital_enable;
        end else if (ADDR == gpio_pkg::OFS_LOCK) begin
            rdata_nxt = unlocked_r ? 32'h0000_0000 : gpio_pkg::LOCKED_READ;
        end else if (ADDR == gpio_pkg::OFS_CR) begin
            rdata_nxt[7:0] = config_commit_r;
        end else if (ADDR == gpio_pkg::OFS_BLOCK_ID) begin
            rdata_nxt[7:0] = gpio_pkg::BLOCK_ID_VAL;
        end else if (ADDR == gpio_pkg::OFS_CELL_ID) begin
            rdata_nxt[7:0] = gpio_pkg::CELL_ID_VAL;
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            RDATA <= 32'h0000_0000;
        end else begin
            RDATA <= RD ? rdata_nxt : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_data_wr;
        WR && is_data;
    endsequence

    a_masked_write_keep: assert property (@(posedge CORE_CLK) disable iff (RESET)
        s_data_wr |=> ((data_r & ~$past(addr_mask)) == ($past(data_r) & ~$past(addr_mask))))
        else $error("Unmasked data bit changed");
    a_masked_write_set: assert property (@(posedge CORE_CLK) disable iff (RESET)
        s_data_wr |=> ((data_r & $past(addr_mask)) == ($past(WDATA[7:0]) & $past(addr_mask))))
        else $error("Masked data bit not written");
    a_data_read_mask: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (RD && is_data) |=> ((RDATA[7:0] & ~$past(addr_mask)) == 8'h00))
        else $error("Unmasked bit read nonzero");
    a_irq_merge: assert property (@(posedge CORE_CLK) disable iff (RESET)
        IRQ == |(irq_raw_status & irq_mask_r))
        else $error("Interrupt output mismatch");
    // Every pin: pending bits not cleared this cycle must still be pending next cycle
    a_edge_sticky: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (|(irq_raw_status & ~clear_pulse))
        |=> ((irq_raw_status & $past(irq_raw_status & ~clear_pulse))
            == $past(irq_raw_status & ~clear_pulse)))
        else $error("Pending status lost without clear");
    a_clear_works: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (clear_pulse[1] && trig_r.sense[1] == 1'b0 && pin_sync[1] == $past(pin_sync[1]))
        |=> (!irq_raw_status[1] || (pin_sync[1] != $past(pin_sync[1]))))
        else $error("Clear did not remove status");
    a_conv_pulse: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CONV_TRIGGER |-> ($past(irq_masked_status[TRIG_PIN]) && !$past(trig_pend_r)))
        else $error("Converter pulse without masked trigger");
    a_afsel_guard: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (WR && wr_hit(ADDR, gpio_pkg::OFS_AFSEL) && !unlocked_r)
        |=> ((alt_function_select_r & PROTECTED) == ($past(alt_function_select_r) & PROTECTED)))
        else $error("Protected select changed while locked");
endmodule
`default_nettype wire

// file: bench/gpio_pads_model.sv
// Pad-side partner: the outside world as seen at the port's pins
`timescale 1ns/1ps
`default_nettype none
module gpio_pads_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // Driven pins read back their own level, the rest see the source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// file: bench/gpio_port_test.sv
// Self-checking testbench of the masked-data port with pin interrupts
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
    $display("[ERR] %s exp %0h got %0h", n, e, s); fails++; end end
module gpio_port_test;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic core_clk = 1'b0; // 50 ns period
    logic reset = 1'b1; // Held for three cycles
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [7:0] pin_in, pin_out, pin_oe;
    logic [7:0] ext_level = 8'h00; // Outside source on every pin
    logic [7:0] alt_out = 8'h00;
    logic [7:0] alt_oe = 8'h00;
    logic irq, conv;
    logic [7:0] alt_in; // Peripheral view of the pins
    gpio_pkg::pad_cfg_t pad_cfg; // Pad settings as presented
    int fails = 0;
    int tests_run = 0;
    int conv_seen = 0; // Converter pulses seen
    // Port clock runs from time zero, so it is enabled before any access
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // Pin 7 stands in for a protected debug pin
    gpio_port #(.PROTECTED(8'h80)) i_dut (.CORE_CLK(core_clk), .RESET(reset), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .ALT_OUT(alt_out), .ALT_OE(alt_oe), .ALT_IN(alt_in), .PAD_CFG(pad_cfg),
        .IRQ(irq), .CONV_TRIGGER(conv));
    gpio_pads_model i_pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in));
    // Count one-cycle converter pulses
    always @(posedge core_clk) begin
        if (conv === 1'b1) conv_seen++;
    end
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rreg(input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        `CHK($sformatf("reg %h", a), e, rdata)
    endtask
    // Bounded wait for the port interrupt level
    task automatic wait_irq(input logic e);
        for (int k = 0; k < 10 && irq !== e; k++) begin
            @(posedge core_clk);
            #1;
        end
        `CHK("irq", e, irq)
        if (irq !== e) conclude();
    endtask
    // Pin source change, then time for sync and detection
    task automatic drive_pins(input logic [7:0] v);
        @(posedge core_clk);
        ext_level <= v;
        repeat (5) @(posedge core_clk);
    endtask
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rreg(12'h500, 32'hff);
        rreg(12'h420, 32'h80);
        rreg(12'h51c, 32'h80);
        `CHK("pad pull-up", 8'h80, pad_cfg.pull_up_select)
        rreg(12'h3fc, 32'h0);
        rreg(12'hfe0, {24'h0, gpio_pkg::BLOCK_ID_VAL});
        rreg(12'hff0, {24'h0, gpio_pkg::CELL_ID_VAL});
        rreg(12'h600, 32'h0);
        // Masked write of eb touches bits 5, 2 and 1 only
        wreg(12'h400, 32'hff);
        wreg(12'h51c, 32'hff);
        wreg(12'h50c, 32'h3c);
        wreg(12'h098, 32'heb);
        #1;
        `CHK("pad den", 8'hff, pad_cfg.digital_enable)
        `CHK("pad odr", 8'h3c, pad_cfg.open_drain_select)
        `CHK("pin_out", 8'h22, pin_out & 8'h7f)
        `CHK("pin_oe", 8'h7f, pin_oe)
        rreg(12'h3fc, 32'h22);
        rreg(12'h0c4, 32'h20);
        // Inputs: data reads follow the pins
        wreg(12'h400, 32'h00);
        drive_pins(8'h5a);
        rreg(12'h3fc, 32'h5a);
        wreg(12'h41c, 32'hff);
        rreg(12'h414, 32'h0);
        // Mask first, then pick rising edge on the trigger pin
        wreg(12'h410, 32'h00);
        wreg(12'h40c, 32'h10);
        wreg(12'h410, 32'h10);
        drive_pins(8'h4a);
        rreg(12'h414, 32'h0);
        drive_pins(8'h5a);
        wait_irq(1'b1);
        rreg(12'h418, 32'h10);
        `CHK("conv", 32'h1, conv_seen)
        drive_pins(8'h4a);
        drive_pins(8'h5a);
        `CHK("conv", 32'h1, conv_seen)
        wreg(12'h41c, 32'h00);
        rreg(12'h414, 32'h10);
        wreg(12'h41c, 32'h10);
        wait_irq(1'b0);
        // Both-edges mode on a masked pin; only a rising edge is driven
        wreg(12'h408, 32'h20);
        drive_pins(8'h7a);
        rreg(12'h414, 32'h20);
        rreg(12'h418, 32'h0);
        `CHK("irq", 1'b0, irq)
        // Low level held by the source re-sets after a clear
        wreg(12'h41c, 32'hff);
        wreg(12'h404, 32'h40);
        drive_pins(8'h3a);
        wreg(12'h41c, 32'h40);
        rreg(12'h414, 32'h40);
        // Commit protection of the debug pin
        wreg(12'h420, 32'h01);
        rreg(12'h420, 32'h81);
        wreg(12'h520, gpio_pkg::UNLOCK_KEY);
        rreg(12'h520, 32'h0);
        wreg(12'h524, 32'hff);
        wreg(12'h420, 32'h01);
        rreg(12'h420, 32'h01);
        // Any other key closes the lock again
        wreg(12'h520, 32'h0);
        rreg(12'h520, gpio_pkg::LOCKED_READ);
        // Peripheral takes pin 0
        @(posedge core_clk);
        alt_out <= 8'h01;
        alt_oe <= 8'h01;
        @(posedge core_clk);
        #1;
        `CHK("alt", 2'h3, {pin_out[0], pin_oe[0]})
        // Two synchroniser stages before the peripheral sees its pin
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("alt_in", 8'h01, alt_in)
        conclude();
    end
endmodule
`default_nettype wire
